// ==== rtl/tps_pkg.sv ====
// Package with register map, field positions, encodings and timing for the power-state sequencer.
package tps_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CHAN_EN = 8'h08;
  localparam logic [7:0] OFS_CAL_EN = 8'h0C;
  localparam logic [7:0] OFS_SAVED = 8'h10;
  localparam logic [7:0] OFS_GATE_MODE = 8'h14;
  localparam logic [7:0] OFS_GATE_FORCE = 8'h18;
  localparam logic [7:0] OFS_ZERO_LEN = 8'h1C;
  localparam logic [7:0] OFS_GATE_GPIO = 8'h20;
  localparam logic [7:0] OFS_GPIO_OWNED = 8'h24;
  localparam logic [7:0] OFS_GATE_STAT = 8'h28;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTL_ENTER = 0;
  localparam int CTL_RECOVER = 1;
  localparam int CTL_EXIT = 2;
  localparam int CTL_BOOT = 3;
  localparam int CTL_CLR_ERR = 4;
  localparam int CTL_PIN_MODE = 8;

  // ----------------------------------------------------------------
  // Status and saved-record field positions
  // ----------------------------------------------------------------
  localparam int STS_MCS_VALID = 4;
  localparam int STS_EXIT_LSB = 8;
  localparam int STS_GPIO_ERR = 12;
  localparam int STS_CHAN_READY = 16;
  localparam int SAVED_CAL_LSB = 16;

  // ----------------------------------------------------------------
  // Idle-gating modes and exit progress codes
  // ----------------------------------------------------------------
  localparam logic [1:0] GM_OFF = 2'h0;
  localparam logic [1:0] GM_AUTO = 2'h1;
  localparam logic [1:0] GM_FORCE = 2'h2;
  localparam logic [1:0] GM_PIN = 2'h3;
  localparam logic [1:0] EXIT_IDLE = 2'h0;
  localparam logic [1:0] EXIT_BUSY = 2'h1;
  localparam logic [1:0] EXIT_DONE = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] ZERO_LEN_RST = 16'h0040;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CHAN_WAKE_NS = 2000;
  localparam logic [8:0] CHAN_WAKE_CYC = 9'(CHAN_WAKE_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ACTIVE,
    ST_ENTERING,
    ST_STANDBY,
    ST_RECOVERED,
    ST_EXITING
  } tps_state_t;

endpackage

// ==== rtl/tps_sequencer.sv ====
// Power-state sequencer: channel standby, chip standby entry and exit, reset power down, Tx idle gating.
`timescale 1ns/1ns
// Notes on behaviour
// (R1) Channel standby powers down; ready within 2us.
// (R2) Host disables all channels for channel standby.
// (R3) Chip standby powers off links and PLLs.
// (R4) Controller low power, clocked from reference clock.
// (R5) Standby drops sync; resync needed before exit.
// (R6) Entry forces serial mode, records active channels.
// (R7) Host restores pin-driven mode itself after exit.
// (R8) Entry records active tracking calibrations.
// (R9) Entry waits for calibration iteration to finish.
// (R10) Host order: recover, sync, cals, links, exit.
// (R11) Exit restores channels, cals; fast attack first.
// (R12) Exit progress status is readable.
// (R13) Host sends no samples before exit done.
// (R14) Reset low powers down and clears everything; the zero-run length reloads ZERO_LEN_RST (0x0040) instead of clearing.
// (R15) Host reprograms device fully after reset.
// (R16) Auto mode gates after programmed zero run.
// (R17) Force bit per channel gates on/off.
// (R18) Per-channel trigger pin; owned pins rejected.
// (R19) Gating status and config readable per channel.
// (R20) Pin mode gates while trigger pin high.
// (R21) Gating stops clocks, attenuates, pauses tracking.
// (R22) Reset overrides every standby and gating state.
module tps_sequencer #(
  parameter int NTX = 4,
  parameter int NRX = 4,
  parameter int NORX = 2,
  parameter int NCAL = 8,
  parameter int NGPIO = 16,
  parameter int GW = 4,
  parameter int ZW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cal_iter_busy,
  input wire logic mcs_done,
  input wire logic fa_done,
  input wire logic [NTX-1:0] tx_zero,
  input wire logic [NGPIO-1:0] gpio_pin,
  output logic [NTX+NRX+NORX-1:0] ch_pwr_en,
  output logic conv_standby,
  output logic dig_clk_en,
  output logic chan_ready,
  output logic link_pwr_en,
  output logic pll_pwr_en,
  output logic ctrl_low_power,
  output logic ctrl_clk_on_ref,
  output logic radio_ctrl_pin_mode,
  output logic [NCAL-1:0] track_cal_en,
  output logic lb_fast_attack,
  output logic [NTX-1:0] tx_gate,
  output logic [NTX-1:0] tx_atten_ramp_down,
  output logic [NTX-1:0] tx_track_pause
);
  import tps_pkg::*;

  localparam int NCH = NTX + NRX + NORX;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tps_state_t st;
    logic pin_mode;
    logic mcs_valid;
    logic gpio_err;
    logic [1:0] exit_st;
    logic [NCH-1:0] ch_en;
    logic [NCH-1:0] saved_ch;
    logic [NCAL-1:0] cal_en;
    logic [NCAL-1:0] saved_cal;
    logic [2*NTX-1:0] gmode;
    logic [NTX-1:0] gforce;
    logic [NTX-1:0] gate;
    logic [ZW-1:0] zlen;
    logic [GW*NTX-1:0] gsel;
    logic [NGPIO-1:0] owned;
    logic [NGPIO-1:0] gp1;
    logic [NGPIO-1:0] gp2;
    logic [NTX-1:0][ZW-1:0] zcnt;
    logic [8:0] wake;
    logic [31:0] rdata;
  } tps_regs_t;

  tps_regs_t r_ff;
  tps_regs_t nxt_r;

  logic wr;
  logic rd_setup;
  logic mapped;
  logic run;
  logic sel_bad;
  logic [1:0] mode_i;
  logic [GW-1:0] sel_i;
  logic [GW-1:0] sel_j;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign mapped = (paddr <= OFS_GATE_STAT) && (paddr[1:0] == 2'h0);
  assign pready = 1'b1;
  // A refused trigger-pin assignment answers with an error as well.
  assign pslverr = psel & penable & (~mapped | (pwrite & (paddr == OFS_GATE_GPIO) & sel_bad)); // (R18)
  assign prdata = r_ff.rdata;

  // ----------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------
  assign run = (r_ff.st == ST_ACTIVE) || (r_ff.st == ST_EXITING);
  assign ch_pwr_en = r_ff.ch_en & {NCH{run}}; // (R1)
  assign conv_standby = ~|ch_pwr_en; // (R1)
  assign dig_clk_en = |ch_pwr_en; // (R1)
  assign chan_ready = (r_ff.wake == CHAN_WAKE_CYC); // (R1)
  // Links and PLLs stay up while entry waits, so the running iteration can finish.
  assign link_pwr_en = run || (r_ff.st == ST_ENTERING) || (r_ff.st == ST_RECOVERED); // (R3)
  assign pll_pwr_en = link_pwr_en; // (R3)
  assign ctrl_low_power = (r_ff.st == ST_STANDBY); // (R4)
  assign ctrl_clk_on_ref = (r_ff.st == ST_STANDBY); // (R4)
  assign radio_ctrl_pin_mode = r_ff.pin_mode;
  assign track_cal_en = r_ff.cal_en & {NCAL{run}}; // (R11)
  assign lb_fast_attack = (r_ff.st == ST_EXITING); // (R11)
  assign tx_gate = r_ff.gate; // (R21)
  assign tx_atten_ramp_down = r_ff.gate; // (R21)
  assign tx_track_pause = r_ff.gate; // (R21)

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    mode_i = GM_OFF;
    sel_i = '0;
    sel_j = '0;
    sel_bad = 1'b0;
    nxt_r.gp1 = gpio_pin;
    nxt_r.gp2 = r_ff.gp1;

    // Trigger pins must be free of other owners and distinct among pin-mode channels.
    for (int i = 0; i < NTX; i++) begin
      sel_i = pwdata[GW*i +: GW];
      if (r_ff.gmode[2*i +: 2] == GM_PIN) begin
        if (r_ff.owned[sel_i]) begin
          sel_bad = 1'b1; // (R18)
        end
        for (int j = 0; j < i; j++) begin
          sel_j = pwdata[GW*j +: GW];
          if ((r_ff.gmode[2*j +: 2] == GM_PIN) && (sel_j == sel_i)) begin
            sel_bad = 1'b1; // (R18)
          end
        end
      end
    end

    // Register writes take effect at the access edge.
    if (wr) begin
      case (paddr)
        OFS_CTRL: begin
          nxt_r.pin_mode = pwdata[CTL_PIN_MODE];
          if (pwdata[CTL_CLR_ERR]) begin
            nxt_r.gpio_err = 1'b0;
          end
        end
        OFS_CHAN_EN: begin
          nxt_r.ch_en = pwdata[NCH-1:0];
        end
        OFS_CAL_EN: begin
          nxt_r.cal_en = pwdata[NCAL-1:0];
        end
        OFS_GATE_MODE: begin
          nxt_r.gmode = pwdata[2*NTX-1:0];
        end
        OFS_GATE_FORCE: begin
          nxt_r.gforce = pwdata[NTX-1:0]; // (R17)
        end
        OFS_ZERO_LEN: begin
          nxt_r.zlen = pwdata[ZW-1:0];
        end
        OFS_GATE_GPIO: begin
          if (sel_bad) begin
            nxt_r.gpio_err = 1'b1; // (R18)
          end else begin
            nxt_r.gsel = pwdata[GW*NTX-1:0]; // (R18)
          end
        end
        OFS_GPIO_OWNED: begin
          nxt_r.owned = pwdata[NGPIO-1:0];
        end
        default: begin
        end
      endcase
    end

    // Sync completion is remembered until the next standby entry.
    if (mcs_done) begin
      nxt_r.mcs_valid = 1'b1;
    end

    // ----------------------------------------------------------------
    // Chip standby sequence
    // ----------------------------------------------------------------
    case (r_ff.st)
      ST_OFF: begin
        if (wr && (paddr == OFS_CTRL) && pwdata[CTL_BOOT]) begin
          nxt_r.st = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (wr && (paddr == OFS_CTRL) && pwdata[CTL_ENTER]) begin
          nxt_r.st = ST_ENTERING;
          nxt_r.pin_mode = 1'b0; // (R6)
          nxt_r.saved_ch = r_ff.ch_en; // (R6)
          nxt_r.saved_cal = r_ff.cal_en; // (R8)
          nxt_r.exit_st = EXIT_IDLE;
        end
      end
      ST_ENTERING: begin
        // No new iteration starts here; entry length follows the one in flight.
        if (!cal_iter_busy) begin
          nxt_r.st = ST_STANDBY; // (R9)
          nxt_r.ch_en = '0; // (R3)
          nxt_r.cal_en = '0; // (R3)
          nxt_r.mcs_valid = 1'b0; // (R5)
        end
      end
      ST_STANDBY: begin
        nxt_r.mcs_valid = 1'b0; // (R5)
        if (wr && (paddr == OFS_CTRL) && pwdata[CTL_RECOVER]) begin
          nxt_r.st = ST_RECOVERED;
        end
      end
      ST_RECOVERED: begin
        // Exit without a fresh sync would leave the converters misaligned, so it is ignored.
        if (wr && (paddr == OFS_CTRL) && pwdata[CTL_EXIT] && r_ff.mcs_valid) begin
          nxt_r.st = ST_EXITING; // (R5)
          nxt_r.ch_en = r_ff.saved_ch; // (R11)
          nxt_r.cal_en = r_ff.saved_cal; // (R11)
          nxt_r.exit_st = EXIT_BUSY; // (R12)
        end
      end
      ST_EXITING: begin
        if (fa_done) begin
          nxt_r.st = ST_ACTIVE; // (R11)
          nxt_r.exit_st = EXIT_DONE; // (R12)
        end
      end
      default: begin
        nxt_r.st = ST_OFF;
      end
    endcase

    // ----------------------------------------------------------------
    // Channel wake timer
    // ----------------------------------------------------------------
    if (!(|ch_pwr_en)) begin
      nxt_r.wake = '0; // (R1)
    end else if (r_ff.wake != CHAN_WAKE_CYC) begin
      nxt_r.wake = r_ff.wake + 9'h001; // (R1)
    end

    // ----------------------------------------------------------------
    // Tx idle gating
    // ----------------------------------------------------------------
    for (int i = 0; i < NTX; i++) begin
      mode_i = r_ff.gmode[2*i +: 2];
      sel_i = r_ff.gsel[GW*i +: GW];
      if (!tx_zero[i]) begin
        nxt_r.zcnt[i] = '0; // (R16)
      end else if (r_ff.zcnt[i] < r_ff.zlen) begin
        nxt_r.zcnt[i] = r_ff.zcnt[i] + 1'b1; // (R16)
      end
      case (mode_i)
        GM_AUTO: begin
          nxt_r.gate[i] = tx_zero[i] && (r_ff.zlen != '0) &&
                          (({1'b0, r_ff.zcnt[i]} + 1'b1) >= {1'b0, r_ff.zlen}); // (R16)
        end
        GM_FORCE: begin
          nxt_r.gate[i] = r_ff.gforce[i]; // (R17)
        end
        GM_PIN: begin
          nxt_r.gate[i] = r_ff.gp2[sel_i]; // (R20)
        end
        default: begin
          nxt_r.gate[i] = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ----------------------------------------------------------------
    if (rd_setup) begin
      case (paddr)
        OFS_CTRL: begin
          nxt_r.rdata = 32'(r_ff.pin_mode) << CTL_PIN_MODE;
        end
        OFS_STATUS: begin
          nxt_r.rdata = 32'(r_ff.st) | (32'(r_ff.mcs_valid) << STS_MCS_VALID) |
                        (32'(r_ff.exit_st) << STS_EXIT_LSB) | (32'(r_ff.gpio_err) << STS_GPIO_ERR) |
                        (32'(chan_ready) << STS_CHAN_READY); // (R12)
        end
        OFS_CHAN_EN: begin
          nxt_r.rdata = 32'(r_ff.ch_en);
        end
        OFS_CAL_EN: begin
          nxt_r.rdata = 32'(r_ff.cal_en);
        end
        OFS_SAVED: begin
          nxt_r.rdata = 32'(r_ff.saved_ch) | (32'(r_ff.saved_cal) << SAVED_CAL_LSB);
        end
        OFS_GATE_MODE: begin
          nxt_r.rdata = 32'(r_ff.gmode); // (R19)
        end
        OFS_GATE_FORCE: begin
          nxt_r.rdata = 32'(r_ff.gforce); // (R19)
        end
        OFS_ZERO_LEN: begin
          nxt_r.rdata = 32'(r_ff.zlen); // (R19)
        end
        OFS_GATE_GPIO: begin
          nxt_r.rdata = 32'(r_ff.gsel); // (R19)
        end
        OFS_GPIO_OWNED: begin
          nxt_r.rdata = 32'(r_ff.owned);
        end
        OFS_GATE_STAT: begin
          nxt_r.rdata = 32'(r_ff.gate); // (R19)
        end
        default: begin
          nxt_r.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset low is the full power-down: every enable, record and setting is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '0; // (R14) (R22)
      r_ff.zlen <= ZERO_LEN_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench of the power-state sequencer.
`timescale 1ns/1ns
`define CHK(a, b) begin \
  n_compared++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); \
  end \
end
module testbench;
  import tps_pkg::*;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, sync_req, err;
  logic cal_iter_busy, mcs_done, fa_done, conv_standby, dig_clk_en, chan_ready, lb_fast_attack;
  logic link_pwr_en, pll_pwr_en, ctrl_low_power, ctrl_clk_on_ref, radio_ctrl_pin_mode;
  logic [7:0] paddr, busy_len, track_cal_en;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] tx_zero, tx_gate, tx_atten_ramp_down, tx_track_pause;
  logic [15:0] gpio_pin;
  logic [9:0] ch_pwr_en;
  int mismatches = 0;
  int n_compared = 0;
  int m_st, m_chan, m_cal, k;
  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  tps_sequencer i_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .cal_iter_busy, .mcs_done, .fa_done, .tx_zero, .gpio_pin, .ch_pwr_en, .conv_standby,
    .dig_clk_en, .chan_ready, .link_pwr_en, .pll_pwr_en, .ctrl_low_power, .ctrl_clk_on_ref,
    .radio_ctrl_pin_mode, .track_cal_en, .lb_fast_attack, .tx_gate, .tx_atten_ramp_down, .tx_track_pause
  );
  tps_host i_host (
    .pclk, .presetn, .lb_fast_attack, .busy_len, .sync_req, .cal_iter_busy, .mcs_done, .fa_done
  );
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic chk_st();
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2:0], m_st[2:0])
  endtask
  task automatic wait_st(input int s);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[2:0] !== s[2:0] && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    m_st = s;
  endtask
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    sync_req <= 1'b0;
    busy_len <= 8'h00;
    tx_zero <= 4'h0;
    gpio_pin <= 16'h0;
    void'($urandom(89838));
    tick(5);
    presetn <= 1'b1;
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_ZERO_LEN, 32'(ZERO_LEN_RST));
    apb(1'b0, 8'h2C, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    wr(OFS_CTRL, 32'h8);
    m_chan = $urandom_range(1, 1023);
    wr(OFS_CHAN_EN, 32'(m_chan));
    tick(200);
    `CHK(chan_ready, 1'b0)
    tick(60);
    `CHK({chan_ready, ch_pwr_en}, {1'b1, m_chan[9:0]})
    wr(OFS_CHAN_EN, 32'h0);
    tick(2);
    `CHK({conv_standby, dig_clk_en}, 2'b10)
    wr(OFS_CHAN_EN, 32'(m_chan));
    m_cal = $urandom_range(0, 255);
    wr(OFS_CAL_EN, 32'(m_cal));
    // The calibration engine is held busy so that entry must stall.
    busy_len <= 8'h40;
    wr(OFS_CTRL, 32'h101);
    tick(20);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h2)
    busy_len <= 8'h00;
    wait_st(3);
    rdc(OFS_SAVED, 32'(m_cal << 16 | m_chan));
    `CHK({link_pwr_en, pll_pwr_en, ctrl_clk_on_ref, radio_ctrl_pin_mode}, 4'b0010)
    `CHK({ctrl_low_power, ctrl_clk_on_ref}, 2'b11)
    `CHK(ch_pwr_en, 10'h0)
    wr(OFS_CTRL, 32'h4);
    chk_st();
    wr(OFS_CTRL, 32'h2);
    m_st = 4;
    wr(OFS_CTRL, 32'h4);
    chk_st();
    sync_req <= 1'b1;
    tick(1);
    sync_req <= 1'b0;
    wr(OFS_CTRL, 32'h4);
    m_st = 5;
    chk_st();
    `CHK(rd[9:8], EXIT_BUSY)
    `CHK({lb_fast_attack, ch_pwr_en, track_cal_en}, {1'b1, m_chan[9:0], m_cal[7:0]})
    wait_st(1);
    `CHK(rd[9:8], EXIT_DONE)
    `CHK({lb_fast_attack, radio_ctrl_pin_mode}, 2'b00)
    wr(OFS_GATE_MODE, 32'hAA);
    k = $urandom_range(0, 15);
    wr(OFS_GATE_FORCE, 32'(k));
    tick(3);
    `CHK(tx_gate, k[3:0])
    `CHK({tx_atten_ramp_down, tx_track_pause}, {2{k[3:0]}})
    rdc(OFS_GATE_STAT, 32'(k));
    wr(OFS_ZERO_LEN, 32'h3);
    wr(OFS_GATE_MODE, 32'h55);
    tx_zero <= 4'hF;
    tick(3);
    `CHK(tx_gate, 4'h0)
    tick(1);
    `CHK(tx_gate, 4'hF)
    tx_zero <= 4'hE;
    tick(3);
    `CHK(tx_gate, 4'hE)
    wr(OFS_GATE_GPIO, 32'h3210);
    wr(OFS_GPIO_OWNED, 32'h0010);
    wr(OFS_GATE_MODE, 32'hFF);
    apb(1'b1, OFS_GATE_GPIO, 32'h3214);
    `CHK(err, 1'b1)
    apb(1'b1, OFS_GATE_GPIO, 32'h3211);
    `CHK(err, 1'b1)
    rdc(OFS_GATE_GPIO, 32'h3210);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[STS_GPIO_ERR], 1'b1)
    wr(OFS_CTRL, 32'h10);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK({rd[STS_GPIO_ERR], rd[2:0]}, 4'h1)
    k = $urandom_range(0, 65535);
    gpio_pin <= 16'(k);
    tick(5);
    `CHK(tx_gate, k[3:0])
    presetn <= 1'b0;
    tick(2);
    `CHK({tx_gate, link_pwr_en, ch_pwr_en}, 15'h0)
    presetn <= 1'b1;
    rdc(OFS_GATE_MODE, 32'h0);
    rdc(OFS_SAVED, 32'h0);
    // Gating is off after reset, so neither zero samples nor trigger pins may gate.
    `CHK(tx_gate, 4'h0)
    // The host has to bring the device up again from scratch.
    wr(OFS_CTRL, 32'h8);
    m_st = 1;
    chk_st();
    stop_test();
  end
endmodule

// ==== testbench/tps_host.sv ====
// Far-side model: calibration iterations, sync and fast-attack completion.
`timescale 1ns/1ns
module tps_host #(
  parameter int FA_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lb_fast_attack,
  input wire logic [7:0] busy_len,
  input wire logic sync_req,
  output logic cal_iter_busy,
  output logic mcs_done,
  output logic fa_done
);
  // ----------------------------------------------------------------
  // Behaviour
  // ----------------------------------------------------------------
  // Iterations run in a 64-cycle frame, so entry latency depends on the phase.
  logic [5:0] phase_ff;
  int fa_cnt;
  assign cal_iter_busy = {2'h0, phase_ff} < busy_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 6'h00;
      fa_cnt <= 0;
      mcs_done <= 1'b0;
      fa_done <= 1'b0;
    end else begin
      phase_ff <= phase_ff + 6'h01;
      mcs_done <= sync_req;
      fa_cnt <= lb_fast_attack ? fa_cnt + 1 : 0;
      fa_done <= lb_fast_attack && fa_cnt == FA_CYC - 1;
    end
  end
endmodule

// ==== testbench/tps_monitor.sv ====
// Checker of the sequencer power outputs.
`timescale 1ns/1ns
module tps_monitor #(
  parameter int NTX = 4,
  parameter int NRX = 4,
  parameter int NORX = 2,
  parameter int NCAL = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cal_iter_busy,
  input wire logic fa_done,
  input wire logic [NTX+NRX+NORX-1:0] ch_pwr_en,
  input wire logic conv_standby,
  input wire logic dig_clk_en,
  input wire logic chan_ready,
  input wire logic link_pwr_en,
  input wire logic pll_pwr_en,
  input wire logic ctrl_low_power,
  input wire logic ctrl_clk_on_ref,
  input wire logic radio_ctrl_pin_mode,
  input wire logic [NCAL-1:0] track_cal_en,
  input wire logic lb_fast_attack,
  input wire logic [NTX-1:0] tx_gate,
  input wire logic [NTX-1:0] tx_atten_ramp_down,
  input wire logic [NTX-1:0] tx_track_pause
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // The counter saturates so that a long active run never wraps under the wake figure.
  logic [8:0] on_cnt_ff;
  logic [8:0] nxt_on_cnt;
  always_comb begin
    nxt_on_cnt = on_cnt_ff;
    if (!(|ch_pwr_en)) begin
      nxt_on_cnt = 9'h000;
    end else if (on_cnt_ff != 9'h1FF) begin
      nxt_on_cnt = on_cnt_ff + 9'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt_ff <= 9'h000;
    end else begin
      on_cnt_ff <= nxt_on_cnt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence exit_wait;
    lb_fast_attack && !fa_done;
  endsequence
  sequence cal_running;
    link_pwr_en && cal_iter_busy;
  endsequence
  standby_links_a: assert property (ctrl_low_power |-> !link_pwr_en && !pll_pwr_en)
    else $error("links powered in standby");
  ref_clock_a: assert property (ctrl_low_power |-> ctrl_clk_on_ref && track_cal_en == '0)
    else $error("controller not on reference clock");
  conv_idle_a: assert property (conv_standby == !(|ch_pwr_en) && dig_clk_en == |ch_pwr_en)
    else $error("converter or clock state wrong");
  wake_early_a: assert property (chan_ready && |ch_pwr_en |-> on_cnt_ff >= 9'h0F0)
    else $error("channels ready too early");
  wake_late_a: assert property (on_cnt_ff >= 9'h104 |-> chan_ready)
    else $error("channels ready too late");
  serial_mode_a: assert property ($rose(ctrl_low_power) |-> !radio_ctrl_pin_mode)
    else $error("pin mode kept in standby");
  cal_finish_a: assert property (cal_running |=> link_pwr_en)
    else $error("powered down during calibration");
  fast_attack_a: assert property (exit_wait |=> lb_fast_attack)
    else $error("fast attack ended early");
  gate_tied_a: assert property (tx_gate == tx_atten_ramp_down && tx_gate == tx_track_pause)
    else $error("gating outputs differ");
endmodule
bind tps_sequencer tps_monitor #(.NTX(NTX), .NRX(NRX), .NORX(NORX), .NCAL(NCAL)) i_mon (
  .pclk, .presetn, .cal_iter_busy, .fa_done, .ch_pwr_en, .conv_standby, .dig_clk_en, .chan_ready,
  .link_pwr_en, .pll_pwr_en, .ctrl_low_power, .ctrl_clk_on_ref, .radio_ctrl_pin_mode,
  .track_cal_en, .lb_fast_attack, .tx_gate, .tx_atten_ramp_down, .tx_track_pause
);
